/* mtog_defs.vh */
/*
 * Constants for the motor thermal overload guard: setting codes, terminal
 * function codes, thresholds and timing counts.
 * Assumes inclusion by bare name from the guard's design files.
 */
`ifndef MTOG_DEFS_VH
`define MTOG_DEFS_VH

// ----------------------------------------------------------------------
// Setting encodings (currents in 0.01 A units, resistance in 0.01 kohm)
// ----------------------------------------------------------------------
`define MTOG_SET_W          16
`define MTOG_CODE_INVALID   16'h270f
`define MTOG_CUR_MAX        16'hc350
`define MTOG_RES_MIN        16'h0032
`define MTOG_RES_MAX        16'h0bb8
`define MTOG_RES_RESET      16'h270f
`define MTOG_CUR_RESET      16'h0190

// ----------------------------------------------------------------------
// Terminal function codes
// ----------------------------------------------------------------------
`define MTOG_FN_W           8
`define MTOG_IN_FN_SELECT2  8'h03
`define MTOG_IN_FN_EXT_TH   8'h07
`define MTOG_OUT_FN_POS     8'h08
`define MTOG_OUT_FN_NEG     8'h6c

// ----------------------------------------------------------------------
// Motor type codes for constant-torque characteristic
// ----------------------------------------------------------------------
`define MTOG_MT_CT_A        8'h01
`define MTOG_MT_CT_B        8'h0d
`define MTOG_MT_CT_C        8'h32
`define MTOG_MT_CT_D        8'h35

// ----------------------------------------------------------------------
// Thresholds and timing
// ----------------------------------------------------------------------
`define MTOG_PRE_PCT        8'h55
`define MTOG_TRIP_PCT       8'h64
`define MTOG_LOW_FREQ       16'h0258
`define MTOG_TICK_US        1000
`define MTOG_CLK_MHZ        100
`define MTOG_TICK_CYCLES    (`MTOG_TICK_US * `MTOG_CLK_MHZ)

`endif

/* mtog_sync.v */
/*
 * Two flip-flop synchroniser for one external level.
 * Assumes clk and rst_b are the guard's own clock and reset.
 */
`timescale 1ns/1ps

module mtog_sync (
  input  wire clk,
  input  wire rst_b,
  input  wire ce,
  input  wire d,
  output reg  q
);

  reg meta_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // mtog_sync

/* mtog_accum.v */
/*
 * Thermal accumulator for one motor: integrates the square of current
 * less a decay of acc/256 (rated is unused), or cools when current is taken as zero.
 * Assumes tick is a one-cycle pulse on clk and current/rated share units.
 */
`timescale 1ns/1ps
`include "mtog_defs.vh"

module mtog_accum #(
  parameter ACC_W = 32
) (
  input  wire                   clk,
  input  wire                   rst_b,
  input  wire                   ce,
  input  wire                   tick,
  input  wire                   active,
  input  wire                   cooling,
  input  wire                   low_speed_derate,
  input  wire [`MTOG_SET_W-1:0] current,
  input  wire [`MTOG_SET_W-1:0] rated,
  output reg  [ACC_W-1:0]       acc_reg
);

  // Gain I^2 less acc/256: rated current settles at rated^2 * 256 (trip)
  wire [ACC_W-1:0]         i_sq   = current * current;
  wire [ACC_W-1:0]         decay  = acc_reg >> 8;
  wire [ACC_W-1:0]         gain   = low_speed_derate ?
                                    i_sq + (i_sq >> 1) : i_sq;
  reg  [ACC_W-1:0]         acc_next;

  always @* begin
    acc_next = acc_reg;
    if (!(active || cooling))
      acc_next = {ACC_W{1'b0}};
    else if (active)
      acc_next = acc_reg - decay + gain;
    else if (acc_reg > decay)
      acc_next = acc_reg - decay;
    else
      acc_next = {ACC_W{1'b0}};
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      acc_reg <= {ACC_W{1'b0}};
    else if (ce && tick)
      acc_reg <= acc_next;
  end

endmodule // mtog_accum

/* mtog_guard.v */
/*
 * Motor thermal overload guard: two-motor electronic thermal integration,
 * pre-alarm, overload trips, external thermal relay and thermistor trip.
 * Assumes settings and the thermistor reading arrive on clk; terminal
 * input pins come from outside and are synchronised.
 */
// Summary of operation
// - First rated current 0..500 A, the reference for motor one.
// - First setting zero disables motor one; transistor guard stays on.
// - Second rated current 0..500 A; 9999 marks it invalid.
// - Select input on bases protection on the second setting.
// - Active motor integrates using measured output current.
// - Cooling motor integrates with current taken as zero.
// - Zero settings, or second current 9999 with second motor type 9999, leave that motor inactive.
// - Select on: motor two integrates, one cools; off the reverse.
// - At 85 percent raise pre-alarm output and display.
// - At 100 percent trip with motor or transistor overload fault.
// - Pre-alarm alone never trips nor stops output.
// - Pre-alarm goes to a terminal coded 8 high or 108 low.
// - Input terminal coded 3 acts as the second-set select.
// - External relay operated trips with external thermal fault.
// - Input terminal coded 7 acts as the external thermal input.
// - Reset clears the accumulated thermal values.
// - Thermistor level 0.5..30 kohm; 9999 disables it.
// - Higher switching frequency shortens transistor trip time.
// - Constant-torque motor types keep full torque below 6 Hz.
// - Second current and thermistor level writable only at display 0.
// - Enabled thermistor reaching the level trips with its fault.
// - Second motor type not 9999 validates motor two when selected.
`timescale 1ns/1ps
`include "mtog_defs.vh"

module mtog_guard #(
  parameter N_IN       = 5,
  parameter N_OUT      = 3,
  parameter ACC_W      = 40,
  parameter TICK_COUNT = `MTOG_TICK_CYCLES
) (
  input  wire                        clk,
  input  wire                        rst_b,
  input  wire                        ce,
  input  wire [N_IN-1:0]             in_terminals,
  input  wire [N_IN*`MTOG_FN_W-1:0]  input_function_codes,
  input  wire [N_OUT*`MTOG_FN_W-1:0] output_function_codes,
  input  wire [`MTOG_SET_W-1:0]      first_rated_current,
  input  wire [`MTOG_SET_W-1:0]      second_rated_current_wdata,
  input  wire                        second_rated_current_we,
  input  wire [`MTOG_SET_W-1:0]      thermistor_trip_level_wdata,
  input  wire                        thermistor_trip_level_we,
  input  wire [`MTOG_SET_W-1:0]      second_motor_type,
  input  wire [7:0]                  motor_type_select,
  input  wire [3:0]                  switching_freq_select,
  input  wire [7:0]                  extended_display_select,
  input  wire [`MTOG_SET_W-1:0]      output_current,
  input  wire [`MTOG_SET_W-1:0]      output_freq,
  input  wire [`MTOG_SET_W-1:0]      drive_rated_current,
  input  wire [`MTOG_SET_W-1:0]      thermistor_resistance,
  input  wire                        fault_clear,
  output reg  [N_OUT-1:0]            out_terminals,
  output reg                         thermal_prealarm_out,
  output reg                         thermal_prealarm_display,
  output reg                         motor_overload_trip,
  output reg                         transistor_overload_trip,
  output reg                         external_thermal_trip,
  output reg                         thermistor_trip,
  output reg                         trip,
  output reg  [`MTOG_SET_W-1:0]      second_rated_current,
  output reg  [`MTOG_SET_W-1:0]      thermistor_trip_level
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // OR of all input terminals whose function code equals code
  function any_fn;
    input [N_IN-1:0]            pins;
    input [N_IN*`MTOG_FN_W-1:0] codes;
    input [`MTOG_FN_W-1:0]      code;
    integer k;
    begin
      any_fn = 1'b0;
      for (k = 0; k < N_IN; k = k + 1)
        if (codes[k*`MTOG_FN_W +: `MTOG_FN_W] == code)
          any_fn = any_fn | pins[k];
    end
  endfunction

  // Threshold = rated^2 * 256 * pct / 100
  function [ACC_W-1:0] level;
    input [`MTOG_SET_W-1:0] rated;
    input [7:0]             pct;
    reg   [ACC_W-1:0]       full;
    begin
      full  = rated * rated;
      level = ((full << 8) / 100) * pct;
    end
  endfunction

  // --------------------------------------------------------------------
  // Terminal synchronisers
  // --------------------------------------------------------------------
  wire [N_IN-1:0] pin_s;

  genvar g;
  generate
    for (g = 0; g < N_IN; g = g + 1) begin : g_sync
      mtog_sync u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .d     (in_terminals[g]),
        .q     (pin_s[g])
      );
    end
  endgenerate

  wire second_set_select =
    any_fn(pin_s, input_function_codes, `MTOG_IN_FN_SELECT2);
  wire external_thermal_input =
    any_fn(pin_s, input_function_codes, `MTOG_IN_FN_EXT_TH);

  // --------------------------------------------------------------------
  // Guarded settings
  // --------------------------------------------------------------------
  wire ext_ok = (extended_display_select == 8'h00);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      second_rated_current  <= `MTOG_CODE_INVALID;
      thermistor_trip_level <= `MTOG_RES_RESET;
    end else if (ce && ext_ok) begin
      if (second_rated_current_we &&
          (second_rated_current_wdata <= `MTOG_CUR_MAX ||
           second_rated_current_wdata == `MTOG_CODE_INVALID))
        second_rated_current <= second_rated_current_wdata;
      if (thermistor_trip_level_we &&
          ((thermistor_trip_level_wdata >= `MTOG_RES_MIN &&
            thermistor_trip_level_wdata <= `MTOG_RES_MAX) ||
           thermistor_trip_level_wdata == `MTOG_CODE_INVALID))
        thermistor_trip_level <= thermistor_trip_level_wdata;
    end
  end

  // --------------------------------------------------------------------
  // Motor mode selection
  // --------------------------------------------------------------------
  wire first_ok  = (first_rated_current != 16'h0000);
  wire sec_zero  = (second_rated_current == 16'h0000);
  wire sec_inv   = (second_rated_current == `MTOG_CODE_INVALID);
  wire mt2_valid = (second_motor_type != `MTOG_CODE_INVALID);
  // Invalid second current with second motor valid uses the first rating
  wire sec_ok    = !sec_zero && (!sec_inv || (mt2_valid && first_ok));
  wire [`MTOG_SET_W-1:0] sec_rated =
    sec_inv ? first_rated_current : second_rated_current;

  // Motor one: active with select off, cooling with select on when motor
  // two exists or second current is zero; with second current 9999 and second motor type 9999 it stays active.
  wire m1_act  = first_ok && (!second_set_select ||
                 (sec_inv && !mt2_valid));
  wire m1_cool = first_ok && !m1_act;
  wire m2_act  = sec_ok && second_set_select;
  wire m2_cool = sec_ok && !second_set_select;

  wire ct_type = (motor_type_select == `MTOG_MT_CT_A) ||
                 (motor_type_select == `MTOG_MT_CT_B) ||
                 (motor_type_select == `MTOG_MT_CT_C) ||
                 (motor_type_select == `MTOG_MT_CT_D);
  // Standard motors lose self-cooling at low speed; constant-torque types
  // do not, so the derate only applies to standard motors below 6 Hz.
  wire derate  = !ct_type && (output_freq < `MTOG_LOW_FREQ);

  // --------------------------------------------------------------------
  // Control tick
  // --------------------------------------------------------------------
  reg [31:0] tick_cnt_reg;
  reg        tick_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end else if (ce) begin
      tick_reg <= (tick_cnt_reg == TICK_COUNT - 1);
      if (tick_cnt_reg == TICK_COUNT - 1)
        tick_cnt_reg <= 32'h0000_0000;
      else
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------------
  // Accumulators
  // --------------------------------------------------------------------
  wire [ACC_W-1:0] acc1;
  wire [ACC_W-1:0] acc2;
  wire [ACC_W-1:0] acc_t;

  mtog_accum #(.ACC_W(ACC_W)) u_acc1 (
    .clk              (clk),
    .rst_b            (rst_b),
    .ce               (ce),
    .tick             (tick_reg),
    .active           (m1_act),
    .cooling          (m1_cool),
    .low_speed_derate (derate),
    .current          (output_current),
    .rated            (first_rated_current),
    .acc_reg          (acc1)
  );

  mtog_accum #(.ACC_W(ACC_W)) u_acc2 (
    .clk              (clk),
    .rst_b            (rst_b),
    .ce               (ce),
    .tick             (tick_reg),
    .active           (m2_act),
    .cooling          (m2_cool),
    .low_speed_derate (derate),
    .current          (output_current),
    .rated            (sec_rated),
    .acc_reg          (acc2)
  );

  // Transistor guard: always active; a higher switching selection adds
  // extra heating so the trip comes sooner.
  wire [`MTOG_SET_W+3:0] tr_sum = output_current +
    (output_current >> 4) * switching_freq_select;
  wire [`MTOG_SET_W-1:0] tr_cur = |tr_sum[19:16] ? 16'hffff : tr_sum[15:0];

  mtog_accum #(.ACC_W(ACC_W)) u_acct (
    .clk              (clk),
    .rst_b            (rst_b),
    .ce               (ce),
    .tick             (tick_reg),
    .active           (1'b1),
    .cooling          (1'b0),
    .low_speed_derate (1'b0),
    .current          (tr_cur),
    .rated            (drive_rated_current),
    .acc_reg          (acc_t)
  );

  // --------------------------------------------------------------------
  // Pre-alarm threshold follows the select input; trip thresholds cover both motors
  // --------------------------------------------------------------------
  wire             use2    = second_set_select && sec_ok;
  wire [ACC_W-1:0] acc_sel = use2 ? acc2 : acc1;
  wire [`MTOG_SET_W-1:0] rated_sel =
    use2 ? sec_rated : first_rated_current;
  wire sel_on  = use2 || first_ok;
  wire pre_hit = sel_on &&
                 (acc_sel >= level(rated_sel, `MTOG_PRE_PCT));
  wire m_hit   = (first_ok && acc1 >= level(first_rated_current,
                  `MTOG_TRIP_PCT)) ||
                 (sec_ok && acc2 >= level(sec_rated, `MTOG_TRIP_PCT));
  wire t_hit   = acc_t >= level(drive_rated_current, `MTOG_TRIP_PCT);
  wire ptc_hit = (thermistor_trip_level != `MTOG_CODE_INVALID) &&
                 (thermistor_resistance >= thermistor_trip_level);

  // --------------------------------------------------------------------
  // Faults: latched until fault_clear; a new hit beats the clear
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      motor_overload_trip      <= 1'b0;
      transistor_overload_trip <= 1'b0;
      external_thermal_trip    <= 1'b0;
      thermistor_trip          <= 1'b0;
      trip                     <= 1'b0;
    end else if (ce) begin
      motor_overload_trip      <= m_hit ||
                                  (motor_overload_trip && !fault_clear);
      transistor_overload_trip <= t_hit ||
                                  (transistor_overload_trip && !fault_clear);
      external_thermal_trip    <= external_thermal_input ||
                                  (external_thermal_trip && !fault_clear);
      thermistor_trip          <= ptc_hit ||
                                  (thermistor_trip && !fault_clear);
      // Pre-alarm is deliberately absent from the trip sum
      trip <= m_hit || t_hit || external_thermal_input || ptc_hit ||
              ((motor_overload_trip || transistor_overload_trip ||
                external_thermal_trip || thermistor_trip) &&
               !fault_clear);
    end
  end

  // --------------------------------------------------------------------
  // Pre-alarm and output terminals
  // --------------------------------------------------------------------
  integer j;
  reg [N_OUT-1:0] out_next;

  always @* begin
    out_next = {N_OUT{1'b0}};
    for (j = 0; j < N_OUT; j = j + 1) begin
      if (output_function_codes[j*`MTOG_FN_W +: `MTOG_FN_W] ==
          `MTOG_OUT_FN_POS)
        out_next[j] = pre_hit;
      else if (output_function_codes[j*`MTOG_FN_W +: `MTOG_FN_W] ==
               `MTOG_OUT_FN_NEG)
        out_next[j] = !pre_hit;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thermal_prealarm_out     <= 1'b0;
      thermal_prealarm_display <= 1'b0;
      out_terminals            <= {N_OUT{1'b0}};
    end else if (ce) begin
      thermal_prealarm_out     <= pre_hit;
      thermal_prealarm_display <= pre_hit;
      out_terminals            <= out_next;
    end
  end

  // Accumulators clear through rst_b (power reset or reset input); a motor's also clears while its setting leaves it inactive.

endmodule // mtog_guard

/* mtog_guard_asserts.sv */
/* Checker for the thermal overload guard: trip causes, guarded writes,
   pre-alarm routing. Assumes a bind to mtog_guard, one clock domain. */
`timescale 1ns/1ps
`include "mtog_defs.vh"

module mtog_guard_asserts #(
  parameter N_IN  = 5,
  parameter N_OUT = 3
) (
  input wire                        clk,
  input wire                        rst_b,
  input wire                        ce,
  input wire [N_IN-1:0]             in_terminals,
  input wire [N_IN*`MTOG_FN_W-1:0]  input_function_codes,
  input wire [N_OUT*`MTOG_FN_W-1:0] output_function_codes,
  input wire [`MTOG_SET_W-1:0]      second_rated_current_wdata,
  input wire                        second_rated_current_we,
  input wire [`MTOG_SET_W-1:0]      thermistor_trip_level_wdata,
  input wire                        thermistor_trip_level_we,
  input wire [7:0]                  extended_display_select,
  input wire [N_OUT-1:0]            out_terminals,
  input wire                        thermal_prealarm_out,
  input wire                        thermal_prealarm_display,
  input wire                        motor_overload_trip,
  input wire                        transistor_overload_trip,
  input wire                        external_thermal_trip,
  input wire                        thermistor_trip,
  input wire                        trip,
  input wire [`MTOG_SET_W-1:0]      second_rated_current,
  input wire [`MTOG_SET_W-1:0]      thermistor_trip_level
);
  reg        ext_hit;
  reg  [1:0] up_reg;
  wire [7:0] code0 = output_function_codes[7:0];
  integer    k;

  always @* begin
    ext_hit = 1'b0;
    for (k = 0; k < N_IN; k = k + 1)
      if (input_function_codes[k*8 +: 8] == `MTOG_IN_FN_EXT_TH)
        ext_hit = ext_hit | in_terminals[k];
  end

  // Terminals read zero just after reset, whatever polarity
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      up_reg <= 2'd0;
    else if (up_reg != 2'd3)
      up_reg <= up_reg + 2'd1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence ext_held;
    (ce && ext_hit) [*4];
  endsequence
  sequence pa_steady;
    (up_reg == 2'd3 && $stable(thermal_prealarm_out) && $stable(code0)) [*2];
  endsequence

  ext_trip_a: assert property (ext_held |-> external_thermal_trip && trip)
    else $error("relay held, no trip");
  trip_cause_a: assert property ($rose(trip) |-> ##[0:1]
    (motor_overload_trip || transistor_overload_trip
     || external_thermal_trip || thermistor_trip))
    else $error("trip without a fault");
  display_match_a: assert property (
    thermal_prealarm_out == thermal_prealarm_display)
    else $error("pre-alarm display differs");
  reset_clear_a: assert property ($rose(rst_b) |->
    !trip && !thermal_prealarm_out)
    else $error("state survived reset");
  locked_write_a: assert property (ce && extended_display_select != 8'h00
    && (second_rated_current_we || thermistor_trip_level_we)
    |=> $stable(second_rated_current) && $stable(thermistor_trip_level))
    else $error("write while locked");
  cur_accept_a: assert property (ce && second_rated_current_we
    && extended_display_select == 8'h00
    && (second_rated_current_wdata <= `MTOG_CUR_MAX
      || second_rated_current_wdata == `MTOG_CODE_INVALID)
    |=> second_rated_current == $past(second_rated_current_wdata))
    else $error("legal current refused");
  level_refuse_a: assert property (ce && thermistor_trip_level_we
    && thermistor_trip_level_wdata != `MTOG_CODE_INVALID
    && (thermistor_trip_level_wdata < `MTOG_RES_MIN
      || thermistor_trip_level_wdata > `MTOG_RES_MAX)
    |=> $stable(thermistor_trip_level))
    else $error("bad level taken");
  pa_route_a: assert property (pa_steady |-> out_terminals[0] ==
    (code0 == `MTOG_OUT_FN_POS ? thermal_prealarm_out
     : code0 == `MTOG_OUT_FN_NEG && !thermal_prealarm_out))
    else $error("pre-alarm terminal wrong");
endmodule // mtog_guard_asserts

bind mtog_guard mtog_guard_asserts #(.N_IN(N_IN), .N_OUT(N_OUT)) u_chk (.*);

/* mtog_motor_model.sv */
/* Motor, external relay and terminal wiring seen by the guard.
   Assumes the bench picks distinct pins for relay and select. */
`timescale 1ns/1ps

module mtog_motor_model #(
  parameter N_IN = 5
) (
  input  wire            clk,
  input  wire            relay_open,
  input  wire            second_sel,
  input  wire [2:0]      ext_pin,
  input  wire [2:0]      sel_pin,
  input  wire [15:0]     load_amps,
  output reg  [N_IN-1:0] in_terminals,
  output reg  [15:0]     output_current
);
  reg [N_IN-1:0] idle_reg = '0;
  reg [N_IN-1:0] pins;

  // Unassigned pins toggle so a guard that reads them cannot get lucky
  always @* begin
    pins = ~idle_reg;
    pins[ext_pin] = relay_open;
    pins[sel_pin] = second_sel;
  end
  always @(posedge clk) begin
    idle_reg       <= ~idle_reg;
    in_terminals   <= pins;
    output_current <= load_amps;
  end
endmodule // mtog_motor_model

/* mtog_guard_test.sv */
/* Self-checking bench for the thermal overload guard.
   Assumes the checker is bound in and a short tick count. */
`timescale 1ns/1ps
`include "mtog_defs.vh"

module mtog_guard_test;
  localparam N_IN  = 5;
  localparam N_OUT = 3;
  reg               clk, rst_b, ce, fault_clear, relay_open, second_sel;
  reg               sec_we, res_we;
  reg  [N_IN*8-1:0] in_codes;
  reg  [23:0]       out_codes;
  reg  [15:0]       first_cur, sec_wdata, res_wdata, load_amps, th_res;
  reg  [15:0]       exp_sec, exp_res;
  reg  [7:0]        display;
  reg  [3:0]        sw_sel;
  reg  [31:0]       rnd;
  integer           fail_count, compares, i, ext_pin, sel_pin, r;
  wire [N_IN-1:0]   in_terms;
  wire [15:0]       out_cur, sec_cur, res_lvl;
  wire [N_OUT-1:0]  out_terms;
  wire              pa_out, pa_disp, mot_trip, tr_trip, ext_trip, th_trip;
  wire              trip;
  wire [3:0]        flags = {th_trip, ext_trip, mot_trip, pa_out};

  mtog_motor_model #(.N_IN(N_IN)) motor (.clk(clk), .relay_open(relay_open),
    .second_sel(second_sel), .ext_pin(ext_pin[2:0]), .sel_pin(sel_pin[2:0]),
    .load_amps(load_amps), .in_terminals(in_terms), .output_current(out_cur));

  mtog_guard #(.N_IN(N_IN), .N_OUT(N_OUT), .TICK_COUNT(4)) uut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .in_terminals(in_terms),
    .input_function_codes(in_codes), .output_function_codes(out_codes),
    .first_rated_current(first_cur), .second_rated_current_wdata(sec_wdata),
    .second_rated_current_we(sec_we), .thermistor_trip_level_wdata(res_wdata),
    .thermistor_trip_level_we(res_we), .second_motor_type(16'h270f),
    .motor_type_select(8'h00), .switching_freq_select(sw_sel),
    .extended_display_select(display), .output_current(out_cur),
    .output_freq(16'h1388), .drive_rated_current(16'hc350),
    .thermistor_resistance(th_res), .fault_clear(fault_clear),
    .out_terminals(out_terms), .thermal_prealarm_out(pa_out),
    .thermal_prealarm_display(pa_disp), .motor_overload_trip(mot_trip),
    .transistor_overload_trip(tr_trip), .external_thermal_trip(ext_trip),
    .thermistor_trip(th_trip), .trip(trip),
    .second_rated_current(sec_cur), .thermistor_trip_level(res_lvl));

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [N_OUT-1:0] exp_out(input [23:0] c, input p);
    integer k;
    for (k = 0; k < N_OUT; k = k + 1)
      exp_out[k] = c[k*8 +: 8] == `MTOG_OUT_FN_POS ? p :
                   c[k*8 +: 8] == `MTOG_OUT_FN_NEG && !p;
  endfunction
  function ok_set(input res, input [15:0] d, input [7:0] disp);
    ok_set = disp == 8'h00 && (d == `MTOG_CODE_INVALID || (res ?
      d >= `MTOG_RES_MIN && d <= `MTOG_RES_MAX : d <= `MTOG_CUR_MAX));
  endfunction

  task check(input string name, input [15:0] seen, input [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      fail_count = fail_count + 1;
    end
  endtask
  task conclude;
    $display("compares %0d, fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wait_hi(input integer idx, input integer bound);
    integer n;
    n = 0;
    while (flags[idx] !== 1'b1 && n < bound) begin
      tick(1);
      n = n + 1;
    end
    if (flags[idx] !== 1'b1) begin
      check("timeout", idx, 16'hffff);
      conclude;
    end
  endtask
  task do_reset;
    rst_b = 1'b0;
    rnd = lfsr(rnd);
    ext_pin = rnd[7:0] % 5;
    sel_pin = (ext_pin + 1 + rnd[8]) % 5;
    r = rnd[11:9] % 3;
    in_codes = '0;
    in_codes[ext_pin*8 +: 8] = `MTOG_IN_FN_EXT_TH;
    in_codes[sel_pin*8 +: 8] = `MTOG_IN_FN_SELECT2;
    out_codes = '0;
    out_codes[r*8 +: 8] = `MTOG_OUT_FN_POS;
    out_codes[((r + 1) % 3)*8 +: 8] = `MTOG_OUT_FN_NEG;
    sw_sel = rnd[15:12];
    exp_sec = `MTOG_CODE_INVALID;
    exp_res = `MTOG_RES_RESET;
    tick(3);
    rst_b = 1'b1;
    tick(3);
    check("pre-alarm", pa_out, 1'b0);
    check("terminals idle", out_terms, exp_out(out_codes, 1'b0));
  endtask
  task write_set(input res, input [15:0] d, input [7:0] disp);
    display = disp;
    sec_we = !res;
    res_we = res;
    sec_wdata = d;
    res_wdata = d;
    if (ok_set(res, d, disp) && res)
      exp_res = d;
    else if (ok_set(res, d, disp))
      exp_sec = d;
    tick(1);
    check("second current", sec_cur, exp_sec);
    check("thermistor level", res_lvl, exp_res);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rst_b, fault_clear, relay_open, second_sel, sec_we, res_we} = 6'h00;
    {in_codes, out_codes, sw_sel, display} = '0;
    {first_cur, sec_wdata, res_wdata, load_amps, th_res} = '0;
    ce = 1'b1;
    rnd = 32'h6cfa1e66;
    fail_count = 0;
    compares = 0;
    do_reset;
    check("second reset", sec_cur, `MTOG_CODE_INVALID);
    check("level reset", res_lvl, `MTOG_RES_RESET);
    for (i = 0; i < 24; i = i + 1) begin
      rnd = lfsr(rnd);
      write_set(rnd[0], rnd[2] ? rnd[31:16] : {4'h0, rnd[27:16]},
                {7'h00, rnd[1] & rnd[3]});
    end
    write_set(1'b0, `MTOG_CUR_MAX, 8'h00);
    write_set(1'b0, 16'hc351, 8'h00);
    write_set(1'b1, `MTOG_RES_MIN - 16'h0001, 8'h00);
    write_set(1'b1, `MTOG_RES_MAX, 8'h00);
    write_set(1'b1, `MTOG_CODE_INVALID, 8'h00);
    write_set(1'b0, `MTOG_CODE_INVALID, 8'h00);
    {sec_we, res_we} = 2'b00;
    th_res = 16'h0c00;
    tick(20);
    check("thermistor off", th_trip, 1'b0);
    relay_open = 1'b1;
    wait_hi(2, 8);
    check("ext trip", trip, 1'b1);
    relay_open = 1'b0;
    fault_clear = 1'b1;
    tick(6);
    fault_clear = 1'b0;
    check("trip cleared", trip, 1'b0);
    // Single-rated 11 A motor, 50 Hz output: 2x rating
    first_cur = 16'h044c;
    load_amps = 16'h0898;
    wait_hi(0, 2000);
    check("display", pa_disp, 1'b1);
    check("early trip", trip, 1'b0);
    tick(2);
    check("alarm terminals", out_terms, exp_out(out_codes, 1'b1));
    wait_hi(1, 2000);
    check("overload trip", {trip, tr_trip}, 2'b10);
    do_reset;
    tick(100);
    check("cleared acc", pa_out, 1'b0);
    first_cur = 16'h0000;
    for (i = 0; i < 60; i = i + 1) begin
      rnd = lfsr(rnd);
      second_sel = rnd[0];
      tick(20);
    end
    check("motor one off", {pa_out, trip}, 2'b00);
    write_set(1'b0, 16'h03e8, 8'h00);
    sec_we = 1'b0;
    second_sel = 1'b0;
    tick(600);
    check("motor two cooling", trip, 1'b0);
    second_sel = 1'b1;
    wait_hi(1, 2000);
    check("second set trip", trip, 1'b1);
    do_reset;
    write_set(1'b1, `MTOG_RES_MAX, 8'h00);
    res_we = 1'b0;
    wait_hi(3, 50);
    check("thermistor trip", trip, 1'b1);
    conclude;
  end
endmodule // mtog_guard_test
